// ---- adc_sequencer_duty_timing_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_duty_timing_bench;
  import seq_timing_pkg::*;
  localparam int TK = 260; // clocks per main-clock tick
  logic        clock, rst_b, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fall_gap, switch_gap;
  logic [1:0]  channel_sel;
  logic        data_ready_b, settling, converting, active_phase;
  logic [3:0]  filter_mode;
  logic [10:0] filter_rate_word;
  logic [15:0] fall_count;
  int          num_errors, tests_run;

  seq_timing dut_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .channel_sel(channel_sel),
    .data_ready_b(data_ready_b), .settling(settling),
    .converting(converting), .active_phase(active_phase),
    .filter_mode(filter_mode), .filter_rate_word(filter_rate_word));
  host_model host_u (.clock(clock), .rst_b(rst_b),
    .channel_sel(channel_sel), .data_ready_b(data_ready_b),
    .fall_count(fall_count), .fall_gap(fall_gap),
    .switch_gap(switch_gap));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_falls(input int n);
    for (int i = 0; i < 90000 && fall_count < 16'(n); i++) @(posedge clock);
    #1;
    chk({16'h0, fall_count}, 32'(n));
  endtask : wait_falls
  task automatic final_report;
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    chk({30'h0, data_ready_b, active_phase}, 32'h3);
    wr(REG_STATUS, 32'hFFFFFFFF);  // read-only, ignored
    wr(4'h5, 32'h12345678);        // unmapped
    rd(REG_CTRL, d);   chk(d, 32'h0);
    rd(REG_SETUP0, d); chk(d, 32'h0);
    rd(4'h5, d);       chk(d, 32'h0);
    rd(REG_STATUS, d); chk(d, 32'h44);
    wr(REG_CTRL, 32'hFFFFFFF6);    // upper bits read back 0
    rd(REG_CTRL, d);   chk(d, 32'h6);
    wr(REG_CTRL, 32'h0);
  endtask : t_regs
  // two channels, settle 32 ticks, sinc3 and sinc3 notch, rate word 1
  task automatic t_seq;
    logic [31:0] d;
    wr(REG_SETUP0, 32'h121);
    wr(REG_SETUP0 + 4'h1, 32'h131);
    rd(REG_SETUP0 + 4'h1, d); chk(d, 32'h131);
    wr(REG_CTRL, 32'h1);
    wait_falls(1);
    chk(switch_gap, 32'(28 * TK));
    chk({30'h0, channel_sel}, 32'h1);
    chk({28'h0, filter_mode}, 32'h3);
    chk({21'h0, filter_rate_word}, 32'h1);
    chk({30'h0, settling, converting}, 32'h2);
    wait_falls(2);
    chk(fall_gap, 32'((32 + 3 * 32) * TK));
    chk({30'h0, channel_sel}, 32'h0);
    chk({28'h0, filter_mode}, 32'h2);
    rd(REG_ACTIVE, d); chk(d, 32'(2 * (32 + 96)));
  endtask : t_seq
  // duty cycling picks up the running sequence: ch1 off, ratio 1/16,
  // ch0 is still settling, so standby follows its conversion
  task automatic t_duty;
    logic [31:0] d;
    wr(REG_SETUP0 + 4'h1, 32'h130);
    wr(REG_CTRL, 32'h7);
    for (int i = 0; i < 30000 && active_phase; i++) @(posedge clock);
    #1;
    chk({29'h0, active_phase, settling, converting}, 32'h0);
    chk({30'h0, channel_sel}, 32'h0);
    rd(REG_STBY, d);
    chk(d, 32'(15 * 3 * 32) - 32'(DUTY_WAKEUP_MCLK));
    rd(REG_ACTIVE, d);
    chk(d, 32'(32 + 3 * 32));
    rd(REG_COUNT, d);
    chk(d, 32'h2);
  endtask : t_duty

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // watchdog: the scenarios need about 100,100 cycles (385 ticks),
  // some 22 ticks of margin on top
  initial begin
    #(106000 * 50);
    num_errors++;
    final_report();
  end
  initial begin
    num_errors = 0; tests_run = 0;
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 4'h0; reg_wdata = 32'h0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_seq();
    t_duty();
    final_report();
  end
endmodule : adc_sequencer_duty_timing_bench
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host side: waits on data-ready edges and times them
module host_model (
  input  wire logic        clock,        // system clock
  input  wire logic        rst_b,        // sync reset, low
  input  wire logic [1:0]  channel_sel,  // device channel
  input  wire logic        data_ready_b, // result ready, low
  output var  logic [15:0] fall_count,   // results seen
  output var  logic [31:0] fall_gap,     // cycles fall to fall
  output var  logic [31:0] switch_gap    // cycles switch to fall
);
  logic [31:0] cyc_q;
  logic [31:0] last_fall_q;
  logic [31:0] last_sw_q;
  logic        drdy_q;
  logic [1:0]  ch_q;

  // a result counts only on a falling edge, never on the switch
  // the cycle counter is cleared too, or every gap would stay unknown
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cyc_q       <= 32'h0;
      last_fall_q <= 32'h0;
      last_sw_q   <= 32'h0;
      drdy_q      <= 1'b1;
      ch_q        <= 2'h0;
      fall_count  <= 16'h0;
      fall_gap    <= 32'h0;
      switch_gap  <= 32'h0;
    end else begin
      cyc_q  <= cyc_q + 32'h1;
      drdy_q <= data_ready_b;
      ch_q   <= channel_sel;
      if (channel_sel != ch_q) last_sw_q <= cyc_q;
      if (drdy_q && !data_ready_b) begin
        fall_count  <= fall_count + 16'h1;
        fall_gap    <= cyc_q - last_fall_q;
        switch_gap  <= cyc_q - last_sw_q;
        last_fall_q <= cyc_q;
      end
    end
  end
endmodule : host_model
`default_nettype wire

// ---- seq_timing.sv ----
// Operation
// - each channel converts with its own setup
// - switch channel right at modulator conversion end
// - data-ready falls after postprocessing delay elapses
// - new settle overlaps previous postprocessing delay
// - data-ready spacing is first time minus previous delay
// - shared setup gives settle plus ideal interval
// - per-channel rate is sequence rate over channels
// - filter outputs follow only filter and rate word
// - sinc4 first 4x32xFS, then every 32xFS
// - sinc3 first 3x32xFS, then every 32xFS
// - sinc4 averaging lasts (4+Avg-1)x32xFS
// - sinc3 averaging lasts (3+Avg-1)x32xFS
// - averaging eight, 76.8 kHz, 11-bit rate word
// - active time sums settle plus ideal times
// - postprocessing delay excluded from active time
// - wake-up overlaps first settle, active unchanged; here wake-up is taken off standby and ends before the first settle
// - standby is ratio times ideal sum minus wake-up
// - standby ratio three or fifteen by select
// - settle code selects 32 doubling to 4096
// - postprocessing delay 28, 62 or 69 clocks
`timescale 1ns/1ns
`default_nettype none
module seq_timing (
  input  wire logic                                 clock,        // 20 MHz
  input  wire logic                                 rst_b,        // sync
  input  wire logic [seq_timing_pkg::ADDR_W-1:0]    reg_addr,     // word
  input  wire logic [seq_timing_pkg::DATA_W-1:0]    reg_wdata,    // data
  input  wire logic                                 reg_wr,       // strobe
  input  wire logic                                 reg_rd,       // strobe
  output var  logic [seq_timing_pkg::DATA_W-1:0]    reg_rdata,    // +1 cyc
  output var  logic [seq_timing_pkg::CH_W-1:0]      channel_sel,  // mux
  output var  logic                                 data_ready_b, // low
  output var  logic                                 settling,     // settle
  output var  logic                                 converting,   // mod on
  output var  logic                                 active_phase, // !stby
  output var  logic [seq_timing_pkg::FILT_W-1:0]    filter_mode,  // type
  output var  logic [seq_timing_pkg::FS_W-1:0]      filter_rate_word // FS
);
  import seq_timing_pkg::*;

  // ========================================================
  // state
  typedef struct packed {
    seq_state_t                  state;
    logic [DIV_W-1:0]            div;
    logic                        tick;
    logic [CTRL_W-1:0]           ctrl;
    logic [NCH-1:0][SETUP_W-1:0] setup;
    logic [CH_W-1:0]             ch;
    logic [SUM_W-1:0]            cnt;
    logic [PP_W-1:0]             pp_cnt;
    logic                        drdy_b;
    logic [SUM_W-1:0]            ideal_sum;
    logic [SUM_W-1:0]            active_acc;
    logic [SUM_W-1:0]            active_last;
    logic [SUM_W-1:0]            stby_last;
    logic [CNT16_W-1:0]          results;
    logic [FILT_W-1:0]           out_filt;
    logic [FS_W-1:0]             out_fs;
    logic                        out_act;
    logic [DATA_W-1:0]           rdata;
  } seq_t;

  localparam seq_t SEQ_RST = '{
    state:   ST_IDLE,
    drdy_b:  1'b1,
    out_act: 1'b1,
    ctrl:    CTRL_RST,
    default: '0
  };

  seq_t q;
  seq_t d;

  // ========================================================
  // channel search helpers
  // nearest enabled channel after 'from', wrapping; 'from' itself
  // has the lowest priority so a lone channel returns itself
  function automatic logic [CH_W-1:0] next_en(
    input logic [NCH-1:0][SETUP_W-1:0] s,
    input logic [CH_W-1:0]             from);
    logic [CH_W-1:0] idx;
    idx     = from;
    next_en = from;
    for (int i = NCH; i >= 1; i--) begin
      idx = from + CH_W'(i);
      if (s[idx][SU_EN]) begin
        next_en = idx;
      end
    end
  endfunction : next_en

  function automatic logic any_enabled(
    input logic [NCH-1:0][SETUP_W-1:0] s);
    any_enabled = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      any_enabled = any_enabled | s[i][SU_EN];
    end
  endfunction : any_enabled

  // ========================================================
  // decoded timing of the current and the next channel
  logic [SETUP_W-1:0] cur;
  logic [SETUP_W-1:0] nxt_setup;
  logic [SETUP_W-1:0] first_setup;
  logic [CH_W-1:0]    nxt;
  logic [CH_W-1:0]    first_ch;
  logic               any_en;
  logic               wrap;
  logic               run;
  logic               duty;
  logic [SUM_W-1:0]   cur_first;
  logic [SUM_W-1:0]   cur_tcnv;
  logic [PP_W-1:0]    cur_dpp;
  logic [SUM_W-1:0]   nxt_settle;
  logic [SUM_W-1:0]   first_settle;
  logic [SUM_W-1:0]   sum_n;
  logic [SUM_W-1:0]   ratio;
  logic [SUM_W-1:0]   prod;
  logic [SUM_W-1:0]   stby_calc;
  logic               conv_end;

  // the whole setup is taken from the channel being converted
  assign cur         = q.setup[q.ch];
  assign nxt         = next_en(q.setup, q.ch);
  assign first_ch    = next_en(q.setup, CH_W'(NCH - 1));
  assign nxt_setup   = q.setup[nxt];
  assign first_setup = q.setup[first_ch];
  assign any_en      = any_enabled(q.setup);
  assign wrap        = (nxt <= q.ch);
  assign run         = q.ctrl[CTRL_RUN];
  assign duty        = q.ctrl[CTRL_DUTY];
  assign cur_first   = first_ideal(cur[SU_FILT +: FILT_W],
                                   cur[SU_FS +: FS_W]);
  assign cur_tcnv    = settled_period(cur[SU_FILT +: FILT_W],
                                      cur[SU_FS +: FS_W]);
  assign cur_dpp     = pp_delay(cur[SU_FILT +: FILT_W],
                                cur[SU_FS +: FS_W]);
  assign nxt_settle  = settle_cycles(nxt_setup[SU_SETTLE +: SETTLE_W]);
  assign first_settle = settle_cycles(first_setup[SU_SETTLE +: SETTLE_W]);
  // standby figures: only ideal times are summed, settle excluded
  assign sum_n       = q.ideal_sum + cur_first;
  assign ratio       = q.ctrl[CTRL_RATIO] ? RATIO_SIXTEENTH
                                          : RATIO_QUARTER;
  assign prod        = ratio * sum_n;
  // a wake-up longer than the product leaves a one-cycle standby
  assign stby_calc   = (prod > DUTY_WAKEUP_MCLK) ?
                       prod - DUTY_WAKEUP_MCLK : SUM_W'(1);
  assign conv_end    = q.tick && (q.state == ST_CONVERT) &&
                       (q.cnt == SUM_W'(1));

  // ========================================================
  // next state
  always_comb begin
    d       = q;
    d.rdata = '0;
    d.tick  = 1'b0;
    // main clock enable, one pulse every MCLK_DIV cycles
    if (q.div == DIV_W'(MCLK_DIV - 1)) begin
      d.div  = '0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + DIV_W'(1);
    end
    // register writes
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        d.ctrl = reg_wdata[CTRL_W-1:0];
      end
      for (int n = 0; n < NCH; n++) begin
        if (reg_addr == REG_SETUP0 + ADDR_W'(n)) begin
          d.setup[n] = reg_wdata[SETUP_W-1:0];
        end
      end
    end
    // register reads, unmapped words read zero
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        d.rdata = DATA_W'(q.ctrl);
      end else if (reg_addr == REG_STATUS) begin
        d.rdata = DATA_W'({q.drdy_b, q.state, q.ch});
      end else if (reg_addr == REG_ACTIVE) begin
        d.rdata = DATA_W'(q.active_last);
      end else if (reg_addr == REG_STBY) begin
        d.rdata = DATA_W'(q.stby_last);
      end else if (reg_addr == REG_COUNT) begin
        d.rdata = DATA_W'(q.results);
      end
      for (int n = 0; n < NCH; n++) begin
        if (reg_addr == REG_SETUP0 + ADDR_W'(n)) begin
          d.rdata = DATA_W'(q.setup[n]);
        end
      end
    end
    if (q.tick) begin
      // postprocessing runs on its own counter, beside the sequencer
      if (q.pp_cnt != '0) begin
        d.pp_cnt = q.pp_cnt - PP_W'(1);
        if (q.pp_cnt == PP_W'(1)) begin
          d.drdy_b  = 1'b0;
          d.results = q.results + CNT16_W'(1);
        end
      end
      if (!run && q.state != ST_IDLE) begin
        // stop at once; a result in postprocessing still completes
        d.state = ST_IDLE;
      end else begin
        unique case (q.state)
          ST_IDLE: begin
            if (run && any_en) begin
              d.ch         = first_ch;
              d.state      = ST_SETTLE;
              d.cnt        = first_settle;
              d.ideal_sum  = '0;
              d.active_acc = '0;
            end
          end
          ST_SETTLE: begin
            // active time counts settle and conversion cycles only
            d.active_acc = q.active_acc + SUM_W'(1);
            if (q.cnt == SUM_W'(1)) begin
              d.state = ST_CONVERT;
              d.cnt   = cur_first;
            end else begin
              d.cnt = q.cnt - SUM_W'(1);
            end
          end
          ST_CONVERT: begin
            d.active_acc = q.active_acc + SUM_W'(1);
            if (q.cnt == SUM_W'(1)) begin
              // result leaves the modulator: line returns high and
              // postprocessing of this channel starts
              d.drdy_b = 1'b1;
              d.pp_cnt = cur_dpp;
              if (duty && wrap) begin
                d.state       = ST_STANDBY;
                d.cnt         = stby_calc;
                d.stby_last   = stby_calc;
                d.active_last = q.active_acc + SUM_W'(1);
                d.out_act     = 1'b0;
                d.ideal_sum   = '0;
                d.active_acc  = '0;
              end else if (nxt == q.ch) begin
                // lone channel keeps converting at the settled period
                d.cnt = cur_tcnv;
                d.ideal_sum = '0;
              end else begin
                // switch now; settle overlaps the running delay, so
                // edges are spaced first time minus previous delay
                d.ch    = nxt;
                d.state = ST_SETTLE;
                d.cnt   = nxt_settle;
                d.ideal_sum = wrap ? '0 : sum_n;
                if (wrap) begin
                  d.active_last = q.active_acc + SUM_W'(1);
                  d.active_acc  = '0;
                end
              end
            end else begin
              d.cnt = q.cnt - SUM_W'(1);
            end
          end
          ST_STANDBY: begin
            // wake-up is already taken off the standby count, so the
            // first settle starts with the oscillator running
            if (q.cnt == SUM_W'(1)) begin
              d.ch      = first_ch;
              d.state   = ST_SETTLE;
              d.cnt     = first_settle;
              d.out_act = 1'b1;
            end else begin
              d.cnt = q.cnt - SUM_W'(1);
            end
          end
        endcase
      end
    end
    if (d.state == ST_IDLE) begin
      d.out_act = 1'b1;
    end
    // filter shaping depends on the setup alone, not on the rate
    d.out_filt = d.setup[d.ch][SU_FILT +: FILT_W];
    d.out_fs   = d.setup[d.ch][SU_FS +: FS_W];
  end

  // ========================================================
  // state register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      q <= SEQ_RST;
    end else begin
      q <= d;
    end
  end

  // ========================================================
  // outputs, each a flip-flop bit
  assign reg_rdata        = q.rdata;
  assign channel_sel      = q.ch;
  assign data_ready_b     = q.drdy_b;
  assign settling         = q.state[1];
  assign converting       = q.state[2];
  assign active_phase     = q.out_act;
  assign filter_mode      = q.out_filt;
  assign filter_rate_word = q.out_fs;

  // ========================================================
  // checks
  property p_switch;
    @(posedge clock) disable iff (!rst_b)
    (conv_end && run && !(duty && wrap) && nxt != q.ch)
      |=> (q.ch == $past(nxt)) && (q.state == ST_SETTLE);
  endproperty
  a_switch: assert property (p_switch)
    else $error("channel did not switch at conversion end");

  property p_overlap;
    @(posedge clock) disable iff (!rst_b)
    (conv_end && run && !(duty && wrap) && nxt != q.ch)
      |=> (q.pp_cnt != '0) && (q.cnt == $past(nxt_settle));
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("settle does not overlap postprocessing");

  property p_dpp_load;
    @(posedge clock) disable iff (!rst_b)
    (conv_end && run) |=> (q.pp_cnt == $past(cur_dpp)) && q.drdy_b;
  endproperty
  a_dpp_load: assert property (p_dpp_load)
    else $error("postprocessing delay not loaded");

  property p_drdy_fall;
    @(posedge clock) disable iff (!rst_b)
    $fell(q.drdy_b) |-> ($past(q.pp_cnt) == PP_W'(1)) && $past(q.tick);
  endproperty
  a_drdy_fall: assert property (p_drdy_fall)
    else $error("data-ready fell before delay elapsed");

  property p_first;
    @(posedge clock) disable iff (!rst_b)
    (q.tick && run && q.state == ST_SETTLE && q.cnt == SUM_W'(1))
      |=> (q.state == ST_CONVERT) && (q.cnt == $past(cur_first));
  endproperty
  a_first: assert property (p_first)
    else $error("first conversion length wrong");

  property p_repeat;
    @(posedge clock) disable iff (!rst_b)
    (conv_end && run && !(duty && wrap) && nxt == q.ch)
      |=> (q.state == ST_CONVERT) && (q.cnt == $past(cur_tcnv));
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("settled conversion length wrong");

  property p_standby;
    @(posedge clock) disable iff (!rst_b)
    (conv_end && run && duty && wrap)
      |=> (q.state == ST_STANDBY) && (q.cnt == $past(stby_calc)) &&
          !q.out_act;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby time wrong");

  property p_active_hold;
    @(posedge clock) disable iff (!rst_b)
    (q.state == ST_STANDBY) |-> (q.active_acc == '0) ##1
      (q.active_acc == '0 || q.state == ST_SETTLE);
  endproperty
  a_active_hold: assert property (p_active_hold)
    else $error("active time counted outside settle or convert");

  property p_settle_min;
    @(posedge clock) disable iff (!rst_b)
    (q.tick && run && q.state == ST_IDLE && any_en)
      |=> (q.state == ST_SETTLE) && (q.cnt >= SETTLE_BASE);
  endproperty
  a_settle_min: assert property (p_settle_min)
    else $error("settle shorter than base count");
endmodule : seq_timing
`default_nettype wire

// ---- seq_timing_pkg.sv ----
`default_nettype none
// ==========================================================
// timing constants, register map, types, period functions
package seq_timing_pkg;
  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned MCLK_HZ  = 76_800;
  localparam int unsigned MCLK_DIV = CLK_HZ / MCLK_HZ;
  localparam longint unsigned US_PER_S = 1_000_000;
  localparam int DIV_W    = 9;
  localparam int NCH      = 4;
  localparam int CH_W     = 2;
  localparam int SUM_W    = 28;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;
  localparam int SETTLE_W = 3;
  localparam int FILT_W   = 4;
  localparam int FS_W     = 11;
  localparam int SETUP_W  = 19;
  localparam int CTRL_W   = 3;
  localparam int PP_W     = 7;
  localparam int CNT16_W  = 16;
  // register word offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SETUP0 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_ACTIVE = 4'h9;
  localparam logic [ADDR_W-1:0] REG_STBY   = 4'hA;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 4'hB;
  // field positions
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_DUTY  = 1;
  localparam int CTRL_RATIO = 2;
  localparam int SU_EN      = 0;
  localparam int SU_SETTLE  = 1;
  localparam int SU_FILT    = 4;
  localparam int SU_FS      = 8;
  // reset values
  localparam logic [CTRL_W-1:0]  CTRL_RST  = 3'h0;
  localparam logic [SETUP_W-1:0] SETUP_RST = 19'h00000;
  // timing figures in main clock cycles
  localparam logic [SUM_W-1:0] SETTLE_BASE = 28'h0000020;
  localparam int CNV_UNIT = 32;
  localparam int AVG      = 8;
  localparam int ORD4     = 4;
  localparam int ORD3     = 3;
  localparam logic [PP_W-1:0]  DPP_SHORT = 7'h1C;
  localparam logic [PP_W-1:0]  DPP_LONG  = 7'h3E;
  localparam logic [PP_W-1:0]  DPP_POST  = 7'h45;
  localparam logic [SUM_W-1:0] RATIO_QUARTER   = 28'h0000003;
  localparam logic [SUM_W-1:0] RATIO_SIXTEENTH = 28'h000000F;
  localparam logic [SUM_W-1:0] DUTY_WAKEUP_MCLK = 28'h0000010;
  // post filter periods in microseconds
  localparam longint unsigned POST1_US = 38330;
  localparam longint unsigned POST2_US = 41670;
  localparam longint unsigned POST3_US = 51670;
  localparam longint unsigned POST4_US = 61670;

  function automatic logic [SUM_W-1:0] us_to_mclk(input longint unsigned us);
    return SUM_W'((us * MCLK_HZ + US_PER_S / 2) / US_PER_S);
  endfunction : us_to_mclk

  localparam logic [SUM_W-1:0] POST1_MCLK = us_to_mclk(POST1_US);
  localparam logic [SUM_W-1:0] POST2_MCLK = us_to_mclk(POST2_US);
  localparam logic [SUM_W-1:0] POST3_MCLK = us_to_mclk(POST3_US);
  localparam logic [SUM_W-1:0] POST4_MCLK = us_to_mclk(POST4_US);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_SETTLE  = 4'h2,
    ST_CONVERT = 4'h4,
    ST_STANDBY = 4'h8
  } seq_state_t;

  typedef enum logic [FILT_W-1:0] {
    FLT_SINC4     = 4'h0,
    FLT_SINC4_AVG = 4'h1,
    FLT_SINC3     = 4'h2,
    FLT_SINC3_NOTCH = 4'h3,
    FLT_SINC3_AVG = 4'h4,
    FLT_POST1     = 4'h5,
    FLT_POST2     = 4'h6,
    FLT_POST3     = 4'h7,
    FLT_POST4     = 4'h8
  } filter_t;

  function automatic logic [SUM_W-1:0] settle_cycles(
    input logic [SETTLE_W-1:0] code);
    return SETTLE_BASE << code;
  endfunction : settle_cycles

  function automatic logic [SUM_W-1:0] settled_period(
    input logic [FILT_W-1:0] f, input logic [FS_W-1:0] fs);
    logic [SUM_W-1:0] base;
    base = SUM_W'((fs == '0) ? 11'h001 : fs) * SUM_W'(CNV_UNIT);
    case (f)
      FLT_SINC4_AVG: settled_period = base * SUM_W'(ORD4 + AVG - 1);
      FLT_SINC3_AVG: settled_period = base * SUM_W'(ORD3 + AVG - 1);
      FLT_POST1:     settled_period = POST1_MCLK;
      FLT_POST2:     settled_period = POST2_MCLK;
      FLT_POST3:     settled_period = POST3_MCLK;
      FLT_POST4:     settled_period = POST4_MCLK;
      default:       settled_period = base;
    endcase
  endfunction : settled_period

  function automatic logic [SUM_W-1:0] first_ideal(
    input logic [FILT_W-1:0] f, input logic [FS_W-1:0] fs);
    logic [SUM_W-1:0] base;
    base = settled_period(f, fs);
    case (f)
      FLT_SINC4:       first_ideal = base * SUM_W'(ORD4);
      FLT_SINC3:       first_ideal = base * SUM_W'(ORD3);
      FLT_SINC3_NOTCH: first_ideal = base * SUM_W'(ORD3);
      default:         first_ideal = base;
    endcase
  endfunction : first_ideal

  function automatic logic [PP_W-1:0] pp_delay(
    input logic [FILT_W-1:0] f, input logic [FS_W-1:0] fs);
    case (f)
      FLT_SINC4, FLT_SINC3, FLT_SINC3_NOTCH:
        pp_delay = (fs > 11'h001) ? DPP_LONG : DPP_SHORT;
      FLT_POST1, FLT_POST2, FLT_POST3, FLT_POST4:
        pp_delay = DPP_POST;
      default: pp_delay = DPP_LONG;
    endcase
  endfunction : pp_delay
endpackage : seq_timing_pkg
`default_nettype wire
